// file: hdl/dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// Register addresses on the register port
`define DSC_ADDR_CFG      4'h8
`define DSC_ADDR_STATUS   4'hA
`define DSC_ADDR_LIMIT    4'hD
// Global control bit positions and reset value
`define DSC_CFG_RUN       0
`define DSC_CFG_RST       1
`define DSC_CFG_AZ        2
`define DSC_CFG_CAL       3
`define DSC_CFG_STBY      4
`define DSC_CFG_SP_LO     8
`define DSC_CFG_DIAG      11
`define DSC_CFG_RESET     16'h0002
// Section pointer codes
`define DSC_SP_LIMIT1     2'h1
`define DSC_SP_LIMIT2     2'h2
// Instruction section one fields
`define DSC_INS_LOOP      0
`define DSC_INS_PAUSE     1
`define DSC_INS_RES8      10
`define DSC_INS_WDOG      11
`define DSC_INS_ACQ_LO    12
// Limit section fields
`define DSC_LIM_SIGN      8
`define DSC_LIM_DIR       9
// Status fields
`define DSC_ST_AZ_DONE    3
`define DSC_ST_CAL_DONE   4
`define DSC_ST_PAUSE      5
`define DSC_ST_PTR_LO     8
// Timing in clock cycles
`define DSC_ACQ12_BASE    13'h0009
`define DSC_ACQ8_BASE     13'h0002
`define DSC_RST_CYC       2
`define DSC_AZ_CYC        76
`define DSC_CAL_CYC       4944
`define DSC_CONV12_CYC    40
`define DSC_CONV8_CYC     20
`endif

// file: hdl/dsc_pkg.sv
package dsc_pkg;
	typedef enum logic [6:0] {
		DSC_IDLE = 7'b0000001,
		DSC_ACQ  = 7'b0000010,
		DSC_CONV = 7'b0000100,
		DSC_CMP1 = 7'b0001000,
		DSC_CMP2 = 7'b0010000,
		DSC_AZ   = 7'b0100000,
		DSC_CAL  = 7'b1000000
	} dsc_state_e;
	// Mux routing: src 0..7 inputs, 8 ground, 9 reference
	typedef struct packed {
		logic       connect;
		logic [3:0] src;
	} dsc_mux_s;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} dsc_req_s;
	typedef struct packed {
		logic        sign;
		logic [11:0] mag;
	} dsc_sample_s;
endpackage : dsc_pkg

// file: hdl/dsc_control.sv
`timescale 1ns/1ns
`include "dsc_cfg.svh"
// Function
// RULE_01: Limit flags: bits 0-7 limit one, 8-15 two
// RULE_02: Set instruction's limit flag when limit passed
// RULE_03: Acquisition time field in section one bits 12-15
// RULE_04: Acquire 9+2D or 2+2D cycles
// RULE_05: Section pointer 01/10 selects limit sections
// RULE_06: Limit sections: magnitude 0-7, sign bit 8
// RULE_07: Watchdog compares one sample, limit one first
// RULE_08: Bit 9 picks above or below trigger
// RULE_09: Limit section bits 10-15 unused
// RULE_10: Eight-input normal mux, negative 000 is ground
// RULE_11: Four-input variant: top bit set connects nothing
// RULE_12: Diagnostic: 000 none, 001 references, rest inputs
// RULE_13: Global control is 16-bit read/write
// RULE_14: Run bit reads sequencer running state
// RULE_15: Run cleared stops after current instruction
// RULE_16: Run set resumes at pointed instruction
// RULE_17: Status bits 8-10 show instruction pointer
// RULE_18: Reset bit stops, zeroes pointer, clears flags
// RULE_19: Reset bit self-clears after two cycles unless standby
// RULE_20: Internal power-up reset; host waits reset zero
// RULE_21: Short calibration starts now or after instruction
// RULE_22: Short calibration 76 cycles, clear bit, flag
// RULE_23: Full calibration deferred past running instruction
// RULE_24: Full calibration 4944 cycles, clear bit, flag
// RULE_25: Compare sign-magnitude limit against 8-bit-plus-sign sample
module dsc_control #(
	parameter bit          FOUR_INPUT = 1'b0,               // Four-input variant
	parameter int unsigned CAL_CYCLES = `DSC_CAL_CYC        // Full calibration length
) (
	input  wire logic               clock,                   // 50 MHz converter clock
	input  wire logic               nrst,                    // Async reset, active low
	input  wire dsc_pkg::dsc_req_s  req,                     // Register access request
	input  wire dsc_pkg::dsc_sample_s sample,                // Converter sample result
	output logic [15:0]             rd_data,                 // Read data, one cycle later
	output dsc_pkg::dsc_mux_s       mux_pos_output,          // Positive mux routing
	output dsc_pkg::dsc_mux_s       mux_neg_output,          // Negative mux routing
	output logic                    acquiring,               // Sample phase active
	output logic                    converting,              // Conversion phase active
	output logic                    calibrating              // Any calibration active
);
	dsc_pkg::dsc_state_e state_q, state_d;
	logic [15:0] instr_mem [8][3];
	logic [15:0] cfg_q, cfg_d;
	logic        run_q, resume_q;
	logic [1:0]  rst_cnt_q;
	logic        cal_q;
	logic [2:0]  ptr_q;
	logic [12:0] cnt_q, cnt_d;
	logic        az_flag_q, cal_flag_q, pause_flag_q;
	logic [15:0] limit_q;
	logic [9:0]  smp_q;
	logic [15:0] rd_data_q;
	dsc_pkg::dsc_mux_s mux_pos_q, mux_neg_q;

	// Register decode
	wire        wr_cfg    = req.wr && (req.addr == `DSC_ADDR_CFG);
	wire        rd_cfg    = req.rd && (req.addr == `DSC_ADDR_CFG);
	wire        rd_status = req.rd && (req.addr == `DSC_ADDR_STATUS);
	wire        rd_limit  = req.rd && (req.addr == `DSC_ADDR_LIMIT);
	wire        mem_hit   = !req.addr[3] && (cfg_q[`DSC_CFG_SP_LO+:2] != 2'h3);
	wire [1:0]  sect      = cfg_q[`DSC_CFG_SP_LO+:2]; // RULE_05
	wire        sreset    = cfg_q[`DSC_CFG_RST];
	wire        standby   = cfg_q[`DSC_CFG_STBY];

	// Current instruction fields
	wire [15:0] ins       = instr_mem[ptr_q][0];
	wire [15:0] lim1      = instr_mem[ptr_q][1];
	wire [15:0] lim2      = instr_mem[ptr_q][2];
	wire        ins_wdog  = ins[`DSC_INS_WDOG];
	wire        ins_short = ins[`DSC_INS_RES8] || ins_wdog;
	wire [3:0]  acq_fld   = ins[`DSC_INS_ACQ_LO+:4]; // RULE_03
	wire [12:0] acq_len   = (ins_short ? `DSC_ACQ8_BASE : `DSC_ACQ12_BASE)
	                        + {8'h00, acq_fld, 1'b0}; // RULE_04
	wire [12:0] conv_len  = ins[`DSC_INS_RES8] ? 13'(`DSC_CONV8_CYC) : 13'(`DSC_CONV12_CYC);
	wire        cnt_zero  = (cnt_q == 13'h0000);
	wire        in_idle   = (state_q == dsc_pkg::DSC_IDLE);
	wire        go_cal    = in_idle && !sreset && cfg_q[`DSC_CFG_CAL]; // RULE_23
	wire        go_az     = in_idle && !sreset && !cfg_q[`DSC_CFG_CAL] && cfg_q[`DSC_CFG_AZ];
	wire        go_seq    = in_idle && !sreset && !cfg_q[`DSC_CFG_CAL] &&
	                        !cfg_q[`DSC_CFG_AZ] && run_q; // RULE_16
	wire        pause_hit = go_seq && ins[`DSC_INS_PAUSE] && !resume_q;
	wire        start_ins = go_seq && !pause_hit;
	wire        az_end    = (state_q == dsc_pkg::DSC_AZ) && cnt_zero && !sreset;
	wire        cal_end   = (state_q == dsc_pkg::DSC_CAL) && cnt_zero && !sreset;
	wire        ins_end   = !sreset && (((state_q == dsc_pkg::DSC_CONV) && cnt_zero) ||
	                        (state_q == dsc_pkg::DSC_CMP2));
	wire [2:0]  ptr_next  = ins[`DSC_INS_LOOP] ? 3'h0 : 3'(ptr_q + 3'h1);

	// Watchdog comparison in signed form, sign plus 8-bit magnitude
	function automatic logic signed [9:0] sm_val(input logic sgn, input logic [7:0] mag);
		sm_val = sgn ? -$signed({2'b00, mag}) : $signed({2'b00, mag}); // RULE_25
	endfunction : sm_val
	function automatic logic limit_hit(input logic signed [9:0] v, input logic [15:0] lim);
		logic signed [9:0] lv;
		lv = sm_val(lim[`DSC_LIM_SIGN], lim[7:0]); // RULE_06 RULE_09
		limit_hit = lim[`DSC_LIM_DIR] ? (v > lv) : (v < lv); // RULE_08
	endfunction : limit_hit
	wire hit1 = (state_q == dsc_pkg::DSC_CMP1) && limit_hit($signed(smp_q), lim1);
	wire hit2 = (state_q == dsc_pkg::DSC_CMP2) && limit_hit($signed(smp_q), lim2);

	// Mux select decode for both variants and diagnostic mode
	function automatic dsc_pkg::dsc_mux_s mux_dec(input logic [2:0] code, input logic neg,
	                                              input logic diag);
		mux_dec.connect = 1'b1;
		mux_dec.src     = {1'b0, code}; // RULE_10
		if (FOUR_INPUT && code[2]) begin
			mux_dec.connect = 1'b0; // RULE_11
		end else if (diag && !FOUR_INPUT && code == 3'h0) begin
			mux_dec.connect = 1'b0; // RULE_12
		end else if (diag && !FOUR_INPUT && code == 3'h1) begin
			mux_dec.src = 4'h9; // RULE_12
		end else if (neg && code == 3'h0) begin
			mux_dec.src = 4'h8; // RULE_10 RULE_11
		end
	endfunction : mux_dec
	wire dsc_pkg::dsc_mux_s pos_sel = mux_dec(ins[4:2], 1'b0, cfg_q[`DSC_CFG_DIAG]);
	wire dsc_pkg::dsc_mux_s neg_sel = mux_dec(ins[7:5], 1'b1, cfg_q[`DSC_CFG_DIAG]);

	// Read mux; unmapped addresses read zero
	wire [15:0] mem_rd   = instr_mem[req.addr[2:0]][sect];
	wire [15:0] cfg_rd   = {cfg_q[15:1], run_q}; // RULE_13 RULE_14
	wire [15:0] stat_rd  = {5'h00, ptr_q, 2'h0, pause_flag_q, cal_flag_q, az_flag_q, 3'h0}; // RULE_17
	wire [15:0] rd_next  = rd_cfg ? cfg_rd :
	                       rd_status ? stat_rd :
	                       rd_limit ? limit_q :
	                       (req.rd && mem_hit) ? mem_rd : 16'h0000;

	// Global control next value; hardware set and write-one both win over self-clear
	always_comb begin
		cfg_d = cfg_q;
		if (az_end)
			cfg_d[`DSC_CFG_AZ] = 1'b0; // RULE_22
		if (cal_end)
			cfg_d[`DSC_CFG_CAL] = 1'b0; // RULE_24
		if (sreset && !standby && rst_cnt_q == 2'(`DSC_RST_CYC - 1))
			cfg_d[`DSC_CFG_RST] = 1'b0; // RULE_19
		if (wr_cfg) begin
			cfg_d[15:4] = req.wdata[15:4];
			cfg_d[3:1]  = cfg_d[3:1] | req.wdata[3:1]; // RULE_21 RULE_23
			cfg_d[0]    = 1'b0;
		end
		if (cfg_d[`DSC_CFG_STBY])
			cfg_d[`DSC_CFG_RST] = 1'b1; // RULE_19
	end

	// Sequencer next state; calibration runs only between instructions
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q - 13'h0001;
		case (state_q)
			dsc_pkg::DSC_IDLE: begin
				cnt_d = cnt_q;
				if (go_cal) begin
					state_d = dsc_pkg::DSC_CAL; // RULE_23
					cnt_d   = 13'(CAL_CYCLES - 1);
				end else if (go_az) begin
					state_d = dsc_pkg::DSC_AZ; // RULE_21
					cnt_d   = 13'(`DSC_AZ_CYC - 1);
				end else if (start_ins) begin
					state_d = dsc_pkg::DSC_ACQ;
					cnt_d   = acq_len - 13'h0001; // RULE_04
				end
			end
			dsc_pkg::DSC_ACQ: begin
				if (cnt_zero) begin
					state_d = ins_wdog ? dsc_pkg::DSC_CMP1 : dsc_pkg::DSC_CONV; // RULE_07
					cnt_d   = conv_len - 13'h0001;
				end
			end
			dsc_pkg::DSC_CONV: begin
				if (cnt_zero)
					state_d = dsc_pkg::DSC_IDLE; // RULE_15
			end
			dsc_pkg::DSC_CMP1: state_d = dsc_pkg::DSC_CMP2; // RULE_07
			dsc_pkg::DSC_CMP2: state_d = dsc_pkg::DSC_IDLE;
			dsc_pkg::DSC_AZ: begin
				if (cnt_zero)
					state_d = dsc_pkg::DSC_IDLE; // RULE_22
			end
			dsc_pkg::DSC_CAL: begin
				if (cnt_zero)
					state_d = dsc_pkg::DSC_IDLE; // RULE_24
			end
			default: state_d = dsc_pkg::DSC_IDLE;
		endcase
		if (sreset)
			state_d = dsc_pkg::DSC_IDLE; // RULE_18
	end

	// State, counter; power-up leaves the reset bit set so it self-clears
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q   <= dsc_pkg::DSC_IDLE;
			cnt_q     <= 13'h0000;
			cfg_q     <= `DSC_CFG_RESET; // RULE_20
			rst_cnt_q <= 2'h0;
			cal_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			cal_q     <= (state_d == dsc_pkg::DSC_AZ) || (state_d == dsc_pkg::DSC_CAL);
			cnt_q     <= cnt_d;
			cfg_q     <= cfg_d;
			rst_cnt_q <= sreset ? 2'(rst_cnt_q + 2'h1) : 2'h0;
		end
	end

	// Run bit: stop request only takes effect at the next instruction boundary
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			run_q    <= 1'b0;
			resume_q <= 1'b0;
		end else if (sreset) begin
			run_q    <= 1'b0; // RULE_18
			resume_q <= 1'b0;
		end else begin
			if (wr_cfg)
				run_q <= req.wdata[`DSC_CFG_RUN]; // RULE_15 RULE_16
			else if (pause_hit)
				run_q <= 1'b0;
			if (pause_hit)
				resume_q <= 1'b1;
			else if (start_ins)
				resume_q <= 1'b0;
		end
	end

	// Instruction pointer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			ptr_q <= 3'h0;
		else if (sreset)
			ptr_q <= 3'h0; // RULE_18
		else if (ins_end)
			ptr_q <= ptr_next; // RULE_17
	end

	// Status flags: clear on read, but a same-cycle event wins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			az_flag_q    <= 1'b0;
			cal_flag_q   <= 1'b0;
			pause_flag_q <= 1'b0;
		end else if (sreset) begin
			az_flag_q    <= 1'b0; // RULE_18
			cal_flag_q   <= 1'b0;
			pause_flag_q <= 1'b0;
		end else begin
			az_flag_q    <= az_end || (az_flag_q && !rd_status); // RULE_22
			cal_flag_q   <= cal_end || (cal_flag_q && !rd_status); // RULE_24
			pause_flag_q <= pause_hit || (pause_flag_q && !rd_status);
		end
	end

	// Limit flags, one per instruction and limit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			limit_q <= 16'h0000;
		else if (sreset)
			limit_q <= 16'h0000;
		else begin
			for (int i = 0; i < 8; i++) begin
				limit_q[i]   <= (hit1 && ptr_q == 3'(i)) || (limit_q[i] && !rd_limit); // RULE_01 RULE_02
				limit_q[i+8] <= (hit2 && ptr_q == 3'(i)) || (limit_q[i+8] && !rd_limit); // RULE_01 RULE_02
			end
		end
	end

	// Captured sample: sign and top eight magnitude bits
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			smp_q <= 10'h000;
		else if (state_q == dsc_pkg::DSC_ACQ && cnt_zero)
			smp_q <= sm_val(sample.sign, sample.mag[11:4]); // RULE_07 RULE_25
	end

	// Instruction memory; no reset, software loads it before starting
	always_ff @(posedge clock) begin
		if (req.wr && mem_hit)
			instr_mem[req.addr[2:0]][sect] <= req.wdata; // RULE_05
	end

	// Registered outputs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= 16'h0000;
			mux_pos_q <= '0;
			mux_neg_q <= '0;
		end else begin
			rd_data_q <= rd_next;
			if (start_ins) begin
				mux_pos_q <= pos_sel; // RULE_10 RULE_11 RULE_12
				mux_neg_q <= neg_sel;
			end
		end
	end

	assign rd_data        = rd_data_q;
	assign mux_pos_output = mux_pos_q;
	assign mux_neg_output = mux_neg_q;
	assign acquiring      = state_q[1];
	assign converting     = state_q[2];
	assign calibrating    = cal_q;

	// Cycles spent in the current state, for timing checks only
	logic [12:0] age_q;
	logic [12:0] acq_exp_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			age_q     <= 13'h0000;
			acq_exp_q <= 13'h0000;
		end else begin
			age_q <= (state_d != state_q) ? 13'h0000 : 13'(age_q + 13'h0001);
			if (start_ins)
				acq_exp_q <= acq_len;
		end
	end

	AST_ACQ_LEN: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
		(state_q == dsc_pkg::DSC_ACQ && cnt_zero && !sreset) |-> age_q == acq_exp_q - 13'h0001)
		else $error("acquisition length wrong");
	AST_AZ_LEN: assert property (@(posedge clock) disable iff (!nrst) // RULE_22
		az_end |-> age_q == 13'(`DSC_AZ_CYC - 1) ##1 (az_flag_q && !cfg_q[`DSC_CFG_AZ]))
		else $error("short calibration timing or flag wrong");
	AST_CAL_LEN: assert property (@(posedge clock) disable iff (!nrst) // RULE_24
		cal_end |-> age_q == 13'(CAL_CYCLES - 1) ##1 (cal_flag_q && !cfg_q[`DSC_CFG_CAL]))
		else $error("full calibration timing or flag wrong");
	AST_CMP_ORDER: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
		(state_q == dsc_pkg::DSC_CMP1 && !sreset) |=> state_q == dsc_pkg::DSC_CMP2)
		else $error("limit two not compared after limit one");
	AST_LIMIT_FLAG: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
		hit2 && !sreset |=> limit_q[8 + $past(ptr_q)])
		else $error("limit two flag not set");
	// Limit one flag lands on the running instruction's bit
	AST_LIMIT_ONE: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
		hit1 && !sreset |=> limit_q[$past(ptr_q)])
		else $error("limit one flag not set");
	AST_RST_CLEAR: assert property (@(posedge clock) disable iff (!nrst) // RULE_19
		($rose(sreset) && !standby) ##1 (!standby && !wr_cfg) |=> !sreset)
		else $error("reset bit did not self-clear in two cycles");
	AST_RST_EFFECT: assert property (@(posedge clock) disable iff (!nrst) // RULE_18
		sreset |=> (ptr_q == 3'h0 && !run_q && state_q == dsc_pkg::DSC_IDLE && limit_q == 16'h0000))
		else $error("reset bit did not clear sequencer");
	AST_STOP_HOLD: assert property (@(posedge clock) disable iff (!nrst) // RULE_15
		(in_idle && !run_q) |=> state_q != dsc_pkg::DSC_ACQ)
		else $error("stopped sequencer started an instruction");
	AST_DEFER_CAL: assert property (@(posedge clock) disable iff (!nrst) // RULE_23 RULE_21
		(converting && (cfg_q[`DSC_CFG_CAL] || cfg_q[`DSC_CFG_AZ])) |=> !calibrating)
		else $error("calibration cut into an instruction");
	AST_FOUR_NONE: assert property (@(posedge clock) disable iff (!nrst) // RULE_11
		(FOUR_INPUT && start_ins && ins[4]) |=> !mux_pos_output.connect)
		else $error("four-input code with top bit connected");
	AST_STATUS_PTR: assert property (@(posedge clock) disable iff (!nrst) // RULE_17
		rd_status |=> rd_data[10:8] == $past(ptr_q))
		else $error("status pointer field wrong");
	// Pointer only moves at an instruction boundary or a soft reset
	AST_PTR_STEP: assert property (@(posedge clock) disable iff (!nrst) // RULE_15
		(!ins_end && !sreset) |=> $stable(ptr_q))
		else $error("instruction pointer moved mid-instruction");
	AST_RUN_READ: assert property (@(posedge clock) disable iff (!nrst) // RULE_14
		rd_cfg |=> rd_data[0] == $past(run_q))
		else $error("run bit readback wrong");

	COV_AZ: cover property (@(posedge clock) disable iff (!nrst) az_end);
	COV_CAL: cover property (@(posedge clock) disable iff (!nrst) cal_end);
	COV_LIMIT: cover property (@(posedge clock) disable iff (!nrst) hit1 ##1 hit2);
	COV_PAUSE: cover property (@(posedge clock) disable iff (!nrst) pause_hit);

	// Calibration request parked behind a running conversion
	COV_DEFER: cover property (@(posedge clock) disable iff (!nrst) converting && cfg_q[`DSC_CFG_AZ]);
endmodule : dsc_control

// file: verification/dsc_host.sv
`timescale 1ns/1ns
`include "dsc_cfg.svh"
// Host side of the register port; the strobe drops for one edge after
// every access so it is never driven twice in one time step
module dsc_host (
	input  wire logic          clock,   // Converter clock
	output dsc_pkg::dsc_req_s  req,     // Register request
	input  wire logic [15:0]   rd_data  // Read data
);
	initial req = '0;
	// One write, held until the taking edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
	endtask : wr
	// One read, data taken once the answering edge has settled
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clock);
		req <= '0;
		#1 d = rd_data;
	endtask : rd
	// No work starts before the reset bit reads zero; bounded poll
	task automatic wait_ready(output bit ok);
		logic [15:0] v;
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			rd(`DSC_ADDR_CFG, v);
			ok = (v[`DSC_CFG_RST] === 1'b0);
		end
	endtask : wait_ready
endmodule : dsc_host

// file: verification/tb_top.sv
`timescale 1ns/1ns
`include "dsc_cfg.svh"
module tb_top;
	localparam int unsigned CAL_N = 100; // Shortened full calibration
	logic                 clock;
	logic                 nrst;
	dsc_pkg::dsc_req_s    req;
	dsc_pkg::dsc_sample_s sample;
	logic [15:0]          rd_data;
	logic [15:0]          v;
	dsc_pkg::dsc_mux_s    mux_p;
	dsc_pkg::dsc_mux_s    mux_n;
	dsc_pkg::dsc_mux_s    mux_p4;
	dsc_pkg::dsc_mux_s    mux_n4;
	logic                 acquiring;
	logic                 converting;
	logic                 calibrating;
	int                   fails = 0;
	int                   cmp_count = 0;
	int                   acq_cnt = 0;
	int                   acq_len = 0;
	int                   cal_cnt = 0;
	int                   cal_len = 0;
	bit                   ok;
	// Source is only meaningful while connected
	wire [4:0] pos_got = {mux_p.connect, mux_p.connect ? mux_p.src : 4'h0};
	wire [4:0] neg_got = {mux_n.connect, mux_n.connect ? mux_n.src : 4'h0};
	wire [4:0] pos_got4 = {mux_p4.connect, mux_p4.connect ? mux_p4.src : 4'h0};
	wire [4:0] neg_got4 = {mux_n4.connect, mux_n4.connect ? mux_n4.src : 4'h0};

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	dsc_control #(.FOUR_INPUT(1'b0), .CAL_CYCLES(CAL_N)) u_dut (
		.clock(clock), .nrst(nrst), .req(req), .sample(sample), .rd_data(rd_data),
		.mux_pos_output(mux_p), .mux_neg_output(mux_n), .acquiring(acquiring),
		.converting(converting), .calibrating(calibrating));

	// Four-input variant on the same stimulus, watched for its mux codes
	dsc_control #(.FOUR_INPUT(1'b1), .CAL_CYCLES(CAL_N)) u_dut_four (
		.clock(clock), .nrst(nrst), .req(req), .sample(sample), .rd_data(),
		.mux_pos_output(mux_p4), .mux_neg_output(mux_n4), .acquiring(),
		.converting(), .calibrating());

	dsc_host u_host (.clock(clock), .req(req), .rd_data(rd_data));

	// Phase lengths measured on the level outputs
	always @(posedge clock) begin
		acq_cnt <= acquiring ? acq_cnt + 1 : 0;
		if (!acquiring && acq_cnt != 0) acq_len <= acq_cnt;
		cal_cnt <= calibrating ? cal_cnt + 1 : 0;
		if (!calibrating && cal_cnt != 0) cal_len <= cal_cnt;
	end

	task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : cmp

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// Reference routing: 8 is ground, 9 the reference pair
	function automatic logic [4:0] mux_exp(input logic [2:0] c, input bit neg, input bit dg,
	                                       input bit four);
		if (four && c[2]) return 5'h00;
		if (dg && !four && c == 3'd0) return 5'h00;
		if (dg && !four && c == 3'd1) return 5'h19;
		if (neg && c == 3'd0) return 5'h18;
		return {2'b10, c};
	endfunction : mux_exp

	function automatic int sm(input logic s, input logic [7:0] m);
		return s ? -int'(m) : int'(m);
	endfunction : sm

	// Run instruction zero once; instruction one pauses the sequencer
	task automatic exec(input logic [15:0] w, l1, l2, input bit dg);
		int vs;
		logic [15:0] f;
		u_host.wr(`DSC_ADDR_CFG, 16'h0002);
		u_host.wait_ready(ok);
		cmp(16'h0001, {15'h0, ok});
		u_host.rd(`DSC_ADDR_STATUS, f);
		cmp(16'h0000, f);
		u_host.wr(`DSC_ADDR_CFG, 16'h0100);
		u_host.wr(4'h0, l1);
		u_host.wr(`DSC_ADDR_CFG, 16'h0200);
		u_host.wr(4'h0, l2);
		u_host.wr(`DSC_ADDR_CFG, 16'h0000);
		u_host.wr(4'h0, w);
		u_host.wr(4'h1, 16'h0002);
		u_host.wr(`DSC_ADDR_CFG, {4'h0, dg, 10'h000, 1'b1});
		for (int i = 0; i < 40 && acquiring !== 1'b1; i++) @(posedge clock);
		#1 cmp({11'h0, mux_exp(w[4:2], 1'b0, dg, 1'b0)}, {11'h0, pos_got});
		cmp({11'h0, mux_exp(w[7:5], 1'b1, dg, 1'b0)}, {11'h0, neg_got});
		cmp({11'h0, mux_exp(w[4:2], 1'b0, dg, 1'b1)}, {11'h0, pos_got4});
		cmp({11'h0, mux_exp(w[7:5], 1'b1, dg, 1'b1)}, {11'h0, neg_got4});
		u_host.rd(`DSC_ADDR_CFG, f);
		cmp(16'h0001, f & 16'h0001);
		for (int i = 0; i < 60 && acquiring !== 1'b0; i++) @(posedge clock);
		for (int i = 0; i < 60 && converting !== 1'b0; i++) @(posedge clock);
		repeat (6) @(posedge clock);
		vs = (w[11] || w[10] ? 2 : 9) + 2 * int'(w[15:12]);
		cmp(vs[15:0], acq_len[15:0]);
		vs = sm(sample.sign, sample.mag[11:4]);
		f = 16'h0000;
		if (w[11]) begin
			f[0] = l1[9] ? vs > sm(l1[8], l1[7:0]) : vs < sm(l1[8], l1[7:0]);
			f[8] = l2[9] ? vs > sm(l2[8], l2[7:0]) : vs < sm(l2[8], l2[7:0]);
		end
		u_host.rd(`DSC_ADDR_LIMIT, v);
		cmp(f, v);
		u_host.rd(`DSC_ADDR_STATUS, v);
		cmp(16'h0120, v);
		u_host.rd(`DSC_ADDR_CFG, v);
		cmp({4'h0, dg, 11'h000}, v);
	endtask : exec

	// Calibration: length, self-clearing command bit, done flag
	task automatic cal(input logic [15:0] cmd, input int n, input logic [15:0] flag);
		u_host.wr(`DSC_ADDR_CFG, cmd);
		if (cmd[0]) begin
			#1;
			cmp(16'h0001, {14'h0, calibrating, acquiring});
		end
		for (int i = 0; i < n + 100 && calibrating !== 1'b1; i++) @(posedge clock);
		for (int i = 0; i < n + 20 && calibrating !== 1'b0; i++) @(posedge clock);
		repeat (2) @(posedge clock);
		cmp(16'(n), cal_len[15:0]);
		u_host.rd(`DSC_ADDR_CFG, v);
		cmp(16'h0000, v & 16'h000E);
		u_host.rd(`DSC_ADDR_STATUS, v);
		cmp(flag, v & 16'h0018);
	endtask : cal

	initial begin
		#400000;
		fails++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		sample = '0;
		void'($urandom(32'hBDDE03B8));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		u_host.wait_ready(ok);
		cmp(16'h0001, {15'h0, ok});
		u_host.wr(`DSC_ADDR_CFG, 16'hF0E0);
		u_host.rd(`DSC_ADDR_CFG, v);
		cmp(16'hF0E0, v);
		// Three sections of one instruction, then the refused places
		for (int s = 0; s < 3; s++) begin
			u_host.wr(`DSC_ADDR_CFG, 16'(s << 8));
			u_host.wr(4'h3, 16'h0055 + 16'(s * 16'h0111));
		end
		for (int s = 0; s < 3; s++) begin
			u_host.wr(`DSC_ADDR_CFG, 16'(s << 8));
			u_host.rd(4'h3, v);
			cmp(16'h0055 + 16'(s * 16'h0111), v);
		end
		u_host.wr(`DSC_ADDR_CFG, 16'h0300);
		u_host.rd(4'h3, v);
		cmp(16'h0000, v);
		u_host.rd(4'hF, v);
		cmp(16'h0000, v);
		cal(16'h0004, 76, 16'h0008);
		cal(16'h0008, CAL_N, 16'h0010);
		// Every select code in normal and diagnostic mode
		for (int k = 0; k < 16; k++) begin
			@(posedge clock);
			sample <= 13'($urandom);
			exec({4'($urandom), 1'b0, 1'($urandom), 2'b00, k[2:0], k[2:0], 2'b00},
				16'h0000, 16'h0000, k[3]);
		end
		// Watchdog with random limits; upper limit bits left random
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			sample <= 13'($urandom);
			exec({4'($urandom), 1'b1, 3'h0, 3'($urandom), 3'($urandom), 2'b00},
				16'($urandom), 16'($urandom), 1'b0);
		end
		// Resume at the paused pointer; short calibration waits for the instruction
		u_host.wr(`DSC_ADDR_CFG, 16'h0000);
		u_host.wr(4'h1, 16'hF000);
		u_host.wr(4'h2, 16'h0002);
		u_host.wr(`DSC_ADDR_CFG, 16'h0001);
		for (int i = 0; i < 40 && acquiring !== 1'b1; i++) @(posedge clock);
		cal(16'h0005, 76, 16'h0008);
		u_host.rd(`DSC_ADDR_STATUS, v);
		cmp(16'h0200, v);
		print_verdict();
	end
endmodule : tb_top
